// ### cdac_far.sv
// behavioural timers and start pin facing the current converter control block
`timescale 1ns/1ps
module cdac_far (
  input wire logic clk,
  output current_dac_pkg::timer_ovf_t ovf,
  output logic pin
);
  initial begin
    ovf = 4'h0;
    pin = 1'b0;
  end
  // an overflow mark lasts one cycle only, as a real timer gives it
  always @(posedge clk) begin
    if (ovf != 4'h0) ovf <= #2 4'h0;
  end
  task automatic overflow(input logic [3:0] m);
    ovf = m;
  endtask
  task automatic set_pin(input logic v);
    pin = v;
  endtask
endmodule

// ### current_dac_consts.svh
// constants, field layout and notes for the current converter control register
// Notes on behaviour
// - Converter runs only while the enable bit is 1.
// - Codes 000..011 load the output on timer 0, 5, 2, 3 overflow.
// - Codes 100, 101, 110 load on rising, falling or either start-pin edge.
// - Code 111 loads the output when software writes the data high byte.
// - With persistence 0, any reset clears the enable bit.
// - With persistence 1, enable survives every reset except power-on.
// - Persistence bit clears on power-on reset or a register write, never on other resets.
// - Range field: 00 is 0.5 mA, 01 is 1.0 mA, 1x is 2.0 mA.
`ifndef CURRENT_DAC_CONSTS_SVH
`define CURRENT_DAC_CONSTS_SVH
`define CDAC_CTRL_ADDR 8'hB9
`define CDAC_EN_BIT 7
`define CDAC_SRC_HI 6
`define CDAC_SRC_LO 4
`define CDAC_RSVD_BIT 3
`define CDAC_RP_BIT 2
`define CDAC_RNG_HI 1
`define CDAC_RNG_LO 0
`define CDAC_SRC_RST 3'h7
`define CDAC_RNG_RST 2'h2
`define CDAC_RNG_HALF 2'h0
`define CDAC_RNG_ONE 2'h1
`define CDAC_SRC_T0 3'h0
`define CDAC_SRC_T5 3'h1
`define CDAC_SRC_T2 3'h2
`define CDAC_SRC_T3 3'h3
`define CDAC_SRC_RISE 3'h4
`define CDAC_SRC_FALL 3'h5
`define CDAC_SRC_ANY 3'h6
`define CDAC_SRC_WR 3'h7
`endif

// ### current_dac_control.sv
// control register and output update logic of the current output converter
`timescale 1ns/1ps
`include "current_dac_consts.svh"
module current_dac_control #(
  parameter int DATA_W = 10
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic por,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic [DATA_W-1:0] data_next,
  input wire logic high_write,
  input wire current_dac_pkg::timer_ovf_t ovf,
  input wire logic external_convert_start,
  output logic converter_enable,
  output current_dac_pkg::range_t output_range,
  output logic [DATA_W-1:0] dac_out,
  output logic update_pulse
);
  // ************************************************************
  // control register
  // ************************************************************
  current_dac_pkg::ctrl_t ctrl_q;
  current_dac_pkg::ctrl_t ctrl_d;
  logic reg_hit;

  function automatic current_dac_pkg::range_t decode_range(input logic [1:0] r);
    if (r[1]) begin
      decode_range = current_dac_pkg::range_two_ma;
    end else if (r[0]) begin
      decode_range = current_dac_pkg::range_one_ma;
    end else begin
      decode_range = current_dac_pkg::range_half_ma;
    end
  endfunction

  assign reg_hit = sfr_wr && (sfr_addr == `CDAC_CTRL_ADDR);

  // por is the power-on reset; rst covers every other reset source
  always_comb begin
    ctrl_d = ctrl_q;
    if (por) begin
      // of the resets only power-on drops the persistence bit; a register write can also clear it
      ctrl_d.enable = 1'b0;
      ctrl_d.source = `CDAC_SRC_RST;
      ctrl_d.persist = 1'b0;
      ctrl_d.range = `CDAC_RNG_RST;
    end else if (rst) begin
      // converter runs on through a warm reset only when persistent
      ctrl_d.enable = ctrl_q.persist & ctrl_q.enable;
      ctrl_d.source = `CDAC_SRC_RST;
      ctrl_d.persist = ctrl_q.persist;
      ctrl_d.range = `CDAC_RNG_RST;
    end else if (reg_hit) begin
      // pairing persistence with enable is left to software, not checked
      ctrl_d.enable = sfr_wdata[`CDAC_EN_BIT];
      ctrl_d.source = sfr_wdata[`CDAC_SRC_HI:`CDAC_SRC_LO];
      ctrl_d.persist = sfr_wdata[`CDAC_RP_BIT];
      ctrl_d.range = sfr_wdata[`CDAC_RNG_HI:`CDAC_RNG_LO];
    end
  end

  always_ff @(posedge clk) begin
    ctrl_q <= ctrl_d;
  end

  always_comb begin
    sfr_rdata = 8'h00;
    if (sfr_addr == `CDAC_CTRL_ADDR) begin
      sfr_rdata[`CDAC_EN_BIT] = ctrl_q.enable;
      sfr_rdata[`CDAC_SRC_HI:`CDAC_SRC_LO] = ctrl_q.source;
      sfr_rdata[`CDAC_RSVD_BIT] = 1'b0;
      sfr_rdata[`CDAC_RP_BIT] = ctrl_q.persist;
      sfr_rdata[`CDAC_RNG_HI:`CDAC_RNG_LO] = ctrl_q.range;
    end
  end

  assign converter_enable = ctrl_q.enable;
  assign output_range = decode_range(ctrl_q.range);

  // ************************************************************
  // output update
  // ************************************************************
  logic fire;
  logic [DATA_W-1:0] out_q;
  logic [DATA_W-1:0] out_d;

  update_trigger trig (
    .clk(clk),
    .rst(rst | por),
    .source(ctrl_q.source),
    .ovf(ovf),
    .start_pin(external_convert_start),
    .high_write(high_write),
    .fire(fire)
  );

  // disabled converter ignores triggers, holding the last value
  assign update_pulse = fire & ctrl_q.enable;

  always_comb begin
    out_d = out_q;
    if (rst | por) begin
      // any reset parks the output code at zero
      out_d = '0;
    end else if (update_pulse) begin
      out_d = data_next;
    end
  end

  always_ff @(posedge clk) begin
    out_q <= out_d;
  end

  assign dac_out = out_q;

  // ************************************************************
  // reset checks
  // ************************************************************
  a_por_clears: assert property (@(posedge clk)
    por |=> (!ctrl_q.persist && !ctrl_q.enable))
    else $error("power-on reset left persistence or enable set");

  a_rst_no_persist: assert property (@(posedge clk)
    (rst && !por && !ctrl_q.persist) |=> !converter_enable)
    else $error("reset without persistence kept enable");

  a_rst_persist: assert property (@(posedge clk)
    (rst && !por && ctrl_q.persist && ctrl_q.enable) |=> converter_enable)
    else $error("persistent enable lost on warm reset");

  a_persist_sticky: assert property (@(posedge clk)
    (rst && !por) |=> ctrl_q.persist == $past(ctrl_q.persist))
    else $error("persistence changed on warm reset");

  a_reset_values: assert property (@(posedge clk)
    por |=> (sfr_rdata[`CDAC_SRC_HI:`CDAC_SRC_LO] == `CDAC_SRC_RST || sfr_addr != `CDAC_CTRL_ADDR)
      && ctrl_q.range == `CDAC_RNG_RST)
    else $error("wrong reset values");

  a_warm_defaults: assert property (@(posedge clk)
    (rst && !por) |=> (ctrl_q.source == `CDAC_SRC_RST && ctrl_q.range == `CDAC_RNG_RST))
    else $error("warm reset left source or range unchanged");

  // ************************************************************
  // register checks
  // ************************************************************
  a_reg_write: assert property (@(posedge clk) disable iff (rst | por)
    reg_hit |=> (converter_enable == $past(sfr_wdata[`CDAC_EN_BIT])
      && ctrl_q.persist == $past(sfr_wdata[`CDAC_RP_BIT])))
    else $error("register write not stored");

  a_other_addr: assert property (@(posedge clk) disable iff (rst | por)
    (sfr_wr && sfr_addr != `CDAC_CTRL_ADDR) |=> ctrl_q == $past(ctrl_q))
    else $error("write to another address changed the register");

  a_read_enable: assert property (@(posedge clk) disable iff (por)
    (sfr_addr == `CDAC_CTRL_ADDR) |-> sfr_rdata[`CDAC_EN_BIT] == converter_enable)
    else $error("enable bit reads back wrong");

  a_rsvd_zero: assert property (@(posedge clk) disable iff (por)
    !sfr_rdata[`CDAC_RSVD_BIT])
    else $error("reserved bit reads as one");

  a_range_map: assert property (@(posedge clk) disable iff (por)
    ctrl_q.range[1] |-> output_range == current_dac_pkg::range_two_ma)
    else $error("range decode wrong");

  a_range_half: assert property (@(posedge clk) disable iff (por)
    (ctrl_q.range == `CDAC_RNG_HALF) |-> output_range == current_dac_pkg::range_half_ma)
    else $error("half range decode wrong");

  a_range_one: assert property (@(posedge clk) disable iff (por)
    (ctrl_q.range == `CDAC_RNG_ONE) |-> output_range == current_dac_pkg::range_one_ma)
    else $error("one range decode wrong");

  // ************************************************************
  // update checks
  // ************************************************************
  a_disabled_hold: assert property (@(posedge clk) disable iff (rst | por)
    !converter_enable |=> dac_out == $past(dac_out))
    else $error("disabled converter changed output");

  a_write_update: assert property (@(posedge clk) disable iff (rst | por)
    (converter_enable && ctrl_q.source == `CDAC_SRC_WR && high_write)
      |=> dac_out == $past(data_next))
    else $error("high byte write did not update output");

  a_write_only: assert property (@(posedge clk) disable iff (rst | por)
    (ctrl_q.source == `CDAC_SRC_WR && !high_write) |-> !update_pulse)
    else $error("write mode updated without a write");

  a_timer0_update: assert property (@(posedge clk) disable iff (rst | por)
    (converter_enable && ctrl_q.source == `CDAC_SRC_T0 && ovf.t0) |-> update_pulse)
    else $error("timer 0 overflow did not update");

  a_timer5_load: assert property (@(posedge clk) disable iff (rst | por)
    (converter_enable && ctrl_q.source == `CDAC_SRC_T5 && ovf.t5)
      |=> dac_out == $past(data_next))
    else $error("timer 5 overflow did not load output");

  a_timer2_load: assert property (@(posedge clk) disable iff (rst | por)
    (converter_enable && ctrl_q.source == `CDAC_SRC_T2 && ovf.t2)
      |=> dac_out == $past(data_next))
    else $error("timer 2 overflow did not load output");

  a_timer3_load: assert property (@(posedge clk) disable iff (rst | por)
    (converter_enable && ctrl_q.source == `CDAC_SRC_T3 && ovf.t3)
      |=> dac_out == $past(data_next))
    else $error("timer 3 overflow did not load output");

  a_pin_any_load: assert property (@(posedge clk) disable iff (rst | por)
    (converter_enable && ctrl_q.source == `CDAC_SRC_ANY
      && external_convert_start != $past(external_convert_start))
      |=> dac_out == $past(data_next))
    else $error("start pin edge did not load output");

  // ************************************************************
  // coverage
  // ************************************************************
  c_warm_persist: cover property (@(posedge clk) rst && ctrl_q.persist && ctrl_q.enable);
  c_pin_update: cover property (@(posedge clk) update_pulse && ctrl_q.source == `CDAC_SRC_ANY);
  c_write_update: cover property (@(posedge clk) update_pulse && ctrl_q.source == `CDAC_SRC_WR);
  c_timer5_update: cover property (@(posedge clk) update_pulse && ctrl_q.source == `CDAC_SRC_T5);
  c_por_sticky: cover property (@(posedge clk) por && ctrl_q.persist);
endmodule

// ### current_dac_control_tb_top.sv
// self-checking bench for the current converter control block
`timescale 1ns/1ps
module current_dac_control_tb_top;
  logic clk = 1'b0, rst = 1'b1, por = 1'b1, wr = 1'b0, hw = 1'b0;
  logic [7:0] addr = 8'hB9, wdata = 8'h00, rdata;
  logic [9:0] dnext = 10'h000, dout;
  logic en, upd, pin;
  logic [3:0] tmask [4] = '{4'h8, 4'h1, 4'h4, 4'h2};
  current_dac_pkg::timer_ovf_t ovf;
  current_dac_pkg::range_t rng;
  int bad_count = 0, tests_run = 0;
  always #12.5 clk = ~clk;
  current_dac_control i_current_dac_control (.clk(clk), .rst(rst), .por(por),
    .sfr_addr(addr), .sfr_wr(wr), .sfr_wdata(wdata), .sfr_rdata(rdata), .data_next(dnext),
    .high_write(hw), .ovf(ovf), .external_convert_start(pin), .converter_enable(en),
    .output_range(rng), .dac_out(dout), .update_pulse(upd));
  cdac_far i_cdac_far (.clk(clk), .ovf(ovf), .pin(pin));
  // ****************
  // access tasks
  // ****************
  task automatic chk(input string what, input logic [9:0] got, input logic [9:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk) #2;
    addr = a;
    wdata = v;
    wr = 1'b1;
    @(posedge clk) #2;
    wr = 1'b0;
    addr = 8'hB9;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk) #2;
    addr = a;
    #5 chk("rdata", {2'b00, rdata}, {2'b00, exp});
    addr = 8'hB9;
  endtask
  task automatic do_reset(input logic p);
    @(posedge clk) #2;
    rst = 1'b1;
    por = p;
    @(posedge clk) #2;
    rst = 1'b0;
    por = 1'b0;
  endtask
  // ev picks the event raised; hit says whether the output must load
  task automatic fire(input logic [2:0] ev, input logic [9:0] v, input logic hit);
    logic [9:0] old;
    old = dout;
    @(posedge clk) #2;
    dnext = v;
    if (ev == 3'h7) hw = 1'b1;
    else if (ev[2]) i_cdac_far.set_pin(ev == 3'h5 ? 1'b0 : ~pin);
    else i_cdac_far.overflow(tmask[ev[1:0]]);
    #5 chk("update_pulse", {9'h000, upd}, {9'h000, hit});
    @(posedge clk) #2;
    hw = 1'b0;
    chk("dac_out", dout, hit ? v : old);
  endtask
  task automatic finish_test;
    if (bad_count == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ****************
  // test sequence
  // ****************
  initial begin
    repeat (16) @(posedge clk);
    #2;
    rst = 1'b0;
    por = 1'b0;
    rd_reg(8'hB9, 8'h72);
    chk("range", {8'h00, rng}, 10'h002);
    wr_reg(8'hB9, 8'hFC);
    rd_reg(8'hB9, 8'hF4);
    for (int r = 0; r < 4; r++) begin
      wr_reg(8'hB9, 8'h70 | 8'(r));
      chk("range", {8'h00, rng}, r[1] ? 10'h002 : 10'(r));
    end
    wr_reg(8'hB8, 8'hFF);
    rd_reg(8'hB8, 8'h00);
    rd_reg(8'hB9, 8'h73);
    fire(3'h7, 10'h3AA, 1'b0);
    chk("enable", {9'h000, en}, 10'h000);
    for (int c = 0; c < 8; c++) begin
      wr_reg(8'hB9, {1'b1, 3'(c), 4'h2});
      chk("enable", {9'h000, en}, 10'h001);
      fire(c == 7 ? 3'h0 : 3'h7, 10'h3FF, 1'b0);
      fire(3'(c), 10'h100 + 10'(c * 16), 1'b1);
    end
    wr_reg(8'hB9, 8'hE2);
    fire(3'h6, 10'h055, 1'b1);
    wr_reg(8'hB9, 8'hF2);
    do_reset(1'b0);
    rd_reg(8'hB9, 8'h72);
    wr_reg(8'hB9, 8'hF4);
    do_reset(1'b0);
    rd_reg(8'hB9, 8'hF6);
    do_reset(1'b1);
    rd_reg(8'hB9, 8'h72);
    finish_test;
  end
  initial begin
    #50000;
    bad_count++;
    finish_test;
  end
endmodule

// ### current_dac_pkg.sv
// types for the current converter control block
package current_dac_pkg;
  typedef enum logic [1:0] {
    range_half_ma,
    range_one_ma,
    range_two_ma
  } range_t;
  typedef struct packed {
    logic t0;
    logic t2;
    logic t3;
    logic t5;
  } timer_ovf_t;
  typedef struct packed {
    logic enable;
    logic [2:0] source;
    logic persist;
    logic [1:0] range;
  } ctrl_t;
endpackage

// ### update_trigger.sv
// selects the event that loads a new converter output value
`timescale 1ns/1ps
`include "current_dac_consts.svh"
module update_trigger (
  input wire logic clk,
  input wire logic rst,
  input wire logic [2:0] source,
  input wire current_dac_pkg::timer_ovf_t ovf,
  input wire logic start_pin,
  input wire logic high_write,
  output logic fire
);
  logic pin_q;
  logic pin_d;
  logic rise;
  logic fall;

  always_comb begin
    pin_d = start_pin;
  end

  // no reset: tracking the pin through reset keeps a stray edge away
  always_ff @(posedge clk) begin
    pin_q <= pin_d;
  end

  assign rise = start_pin & ~pin_q;
  assign fall = ~start_pin & pin_q;

  always_comb begin
    unique case (source)
      `CDAC_SRC_T0: fire = ovf.t0;
      `CDAC_SRC_T5: fire = ovf.t5;
      `CDAC_SRC_T2: fire = ovf.t2;
      `CDAC_SRC_T3: fire = ovf.t3;
      `CDAC_SRC_RISE: fire = rise;
      `CDAC_SRC_FALL: fire = fall;
      `CDAC_SRC_ANY: fire = rise | fall;
      `CDAC_SRC_WR: fire = high_write;
    endcase
  end

  a_rise_fires: assert property (@(posedge clk) disable iff (rst)
    (source == `CDAC_SRC_RISE && start_pin && !$past(start_pin)) |-> fire)
    else $error("rising edge did not fire update");
  a_fall_fires: assert property (@(posedge clk) disable iff (rst)
    (source == `CDAC_SRC_FALL && !start_pin && $past(start_pin)) |-> fire)
    else $error("falling edge did not fire update");
endmodule
